// ==== hw/ext_irq_and_vector_select.sv ====
/*
  External interrupt front-end with protected vector-base relocation.
  Holds the vector relocation control, the dedicated pin sensing and two
  eight-pin change groups, all reached over classic Wishbone (32-bit).
  Assumes pins are synchronous to clk_i, the core reports its global
  enable, vector entries and instruction completion as inputs.
*/
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ns

module ext_irq_and_vector_select
    import ext_irq_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Core status
    input  wire logic              global_irq_enable_i,
    input  wire logic              exec_in_boot_i,
    input  wire logic              instr_done_i,
    input  wire logic              app_section_lock_i,
    input  wire logic              boot_section_lock_i,
    // Vector entry acknowledges
    input  wire logic              dedicated_entry_i,
    input  wire logic              upper_entry_i,
    input  wire logic              lower_entry_i,
    // External pins
    input  wire logic              dedicated_ext_irq_i,
    input  wire logic [15:0]       pin_change_inputs_i,
    // Interrupt requests and control
    output logic                   dedicated_irq_req_o,
    output logic                   pin_change_irq_upper_o,
    output logic                   pin_change_irq_lower_o,
    output logic                   irq_block_o,
    output logic                   vector_base_select_o,
    output logic                   wake_o
);

    // ========================================================
    // Parameter check
    initial
    begin
        if (ADDR_W < 9)
            $error("ADDR_W too small for the register map");
    end

    // ========================================================
    // Bus decode
    logic [ADDR_W-3:0] word_idx;
    logic              fire;
    logic              wr_fire;
    logic              lane0_wr;
    logic              hit_ctl;
    logic              hit_flag;
    logic              hit_mask;
    logic              hit_sense;
    logic              hit_pcl;
    logic              hit_pcu;

    // Request taken at the edge where ack is high
    assign word_idx  = adr_i[ADDR_W-1:2];
    assign fire      = cyc_i && stb_i && ack_o;
    assign wr_fire   = fire && we_i;
    assign lane0_wr  = wr_fire && sel_i[0];
    assign hit_ctl   = (word_idx == (ADDR_W-2)'(IDX_CPU_CONTROL));
    assign hit_flag  = (word_idx == (ADDR_W-2)'(IDX_EXT_IRQ_FLAG));
    assign hit_mask  = (word_idx == (ADDR_W-2)'(IDX_EXT_IRQ_MASK));
    assign hit_sense = (word_idx == (ADDR_W-2)'(IDX_SENSE_CONTROL));
    assign hit_pcl   = (word_idx == (ADDR_W-2)'(IDX_PC_MASK_LOWER));
    assign hit_pcu   = (word_idx == (ADDR_W-2)'(IDX_PC_MASK_UPPER));

    // ========================================================
    // Registers
    logic [7:0]  mask_reg;
    logic [1:0]  sense_reg;
    logic [7:0]  pcl_reg;
    logic [7:0]  pcu_reg;
    logic        select_reg;
    logic        dflag_reg;
    logic        uflag_reg;
    logic        lflag_reg;
    seq_state_t  seq_reg;
    logic [2:0]  cnt_reg;

    // Mask, sense and pin masks
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mask_reg  <= MASK_RESET;
            sense_reg <= SENSE_RESET;
            pcl_reg   <= PC_RESET;
            pcu_reg   <= PC_RESET;
        end
        else if (lane0_wr)
        begin
            if (hit_mask)
            begin
                mask_reg <= MASK_RESET;
                mask_reg[UPPER_BIT]     <= dat_i[UPPER_BIT];
                mask_reg[LOWER_BIT]     <= dat_i[LOWER_BIT];
                mask_reg[DEDICATED_BIT] <= dat_i[DEDICATED_BIT];
            end
            if (hit_sense)
                sense_reg <= dat_i[SENSE_HI_BIT:SENSE_LO_BIT];
            if (hit_pcl)
                pcl_reg <= dat_i[7:0];
            if (hit_pcu)
                pcu_reg <= dat_i[7:0];
        end
    end

    // ========================================================
    // Vector relocation sequence
    logic unlock_wr;
    logic sel_wr;
    logic unlock_bit;

    // Unlock write, or a select write inside the window
    assign unlock_wr  = lane0_wr && hit_ctl && dat_i[UNLOCK_BIT];
    assign sel_wr     = lane0_wr && hit_ctl && !dat_i[UNLOCK_BIT]
                        && (seq_reg == SEQ_WINDOW);
    assign unlock_bit = (seq_reg == SEQ_WINDOW);

    // Window counts four cycles, select write ends it early
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            seq_reg <= SEQ_IDLE;
            cnt_reg <= 3'h0;
        end
        else
        begin
            case (seq_reg)
                SEQ_IDLE:
                begin
                    if (unlock_wr)
                    begin
                        seq_reg <= SEQ_WINDOW;
                        cnt_reg <= UNLOCK_LOAD;
                    end
                end
                SEQ_WINDOW:
                begin
                    if (sel_wr)
                        seq_reg <= SEQ_HOLD;
                    else if (unlock_wr)
                        cnt_reg <= UNLOCK_LOAD;
                    else if (cnt_reg == 3'h0)
                        seq_reg <= SEQ_IDLE;
                    else
                        cnt_reg <= cnt_reg - 3'h1;
                end
                SEQ_HOLD:
                begin
                    if (instr_done_i)
                        seq_reg <= SEQ_IDLE;
                end
                default:
                    seq_reg <= SEQ_IDLE;
            endcase
        end
    end

    // Select only changes through the protected sequence
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            select_reg <= 1'b0;
        else if (sel_wr)
            select_reg <= dat_i[SELECT_BIT];
    end

    assign vector_base_select_o = select_reg;

    // ========================================================
    // Interrupt blocking
    logic seq_block;
    logic sect_block;

    // Block from the unlock cycle on; global enable is only read
    assign seq_block  = unlock_wr || (seq_reg != SEQ_IDLE);
    assign sect_block =
        (select_reg && app_section_lock_i && !exec_in_boot_i)
        || (!select_reg && boot_section_lock_i && exec_in_boot_i);
    assign irq_block_o = seq_block || sect_block;

    // ========================================================
    // Dedicated pin sampling and edge detection
    logic pin_cur;
    logic pin_prev;
    logic edge_evt;
    logic rise;
    logic fall;

    // Two samples of the pin, pins read regardless of direction
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_cur  <= 1'b1;
            pin_prev <= 1'b1;
        end
        else
        begin
            pin_cur  <= dedicated_ext_irq_i;
            pin_prev <= pin_cur;
        end
    end

    assign rise = pin_cur && !pin_prev;
    assign fall = !pin_cur && pin_prev;

    // Edge event by sense mode
    always_comb
    begin
        case (sense_mode_t'(sense_reg))
            SENSE_ANY_EDGE: edge_evt = rise || fall;
            SENSE_FALLING:  edge_evt = fall;
            SENSE_RISING:   edge_evt = rise;
            default:        edge_evt = 1'b0;
        endcase
    end

    // ========================================================
    // Pin-change sampling
    logic [15:0] pc_cur;
    logic [15:0] pc_prev;
    logic [7:0]  chg_lower;
    logic [7:0]  chg_upper;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_cur  <= 16'h0000;
            pc_prev <= 16'h0000;
        end
        else
        begin
            pc_cur  <= pin_change_inputs_i;
            pc_prev <= pc_cur;
        end
    end

    // Masked toggles per group
    assign chg_lower = (pc_cur[7:0] ^ pc_prev[7:0]) & pcl_reg;
    assign chg_upper = (pc_cur[15:8] ^ pc_prev[15:8]) & pcu_reg;

    // ========================================================
    // Flags: set wins over any clear
    logic flag_wr;

    assign flag_wr = lane0_wr && hit_flag;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dflag_reg <= 1'b0;
            uflag_reg <= 1'b0;
            lflag_reg <= 1'b0;
        end
        else
        begin
            if (sense_reg == SENSE_LOW_LEVEL)
                dflag_reg <= 1'b0;
            else if (edge_evt)
                dflag_reg <= 1'b1;
            else if (dedicated_entry_i
                     || (flag_wr && dat_i[DEDICATED_BIT]))
                dflag_reg <= 1'b0;
            if (|chg_upper)
                uflag_reg <= 1'b1;
            else if (upper_entry_i || (flag_wr && dat_i[UPPER_BIT]))
                uflag_reg <= 1'b0;
            if (|chg_lower)
                lflag_reg <= 1'b1;
            else if (lower_entry_i || (flag_wr && dat_i[LOWER_BIT]))
                lflag_reg <= 1'b0;
        end
    end

    // ========================================================
    // Requests to the core
    logic level_low;
    logic gate;

    assign level_low = (sense_reg == SENSE_LOW_LEVEL) && !pin_cur;
    assign gate      = global_irq_enable_i && !irq_block_o;

    // Level request lasts only while the pin stays low
    assign dedicated_irq_req_o = gate && mask_reg[DEDICATED_BIT]
        && (level_low || dflag_reg);
    assign pin_change_irq_upper_o = gate && mask_reg[UPPER_BIT]
        && uflag_reg;
    assign pin_change_irq_lower_o = gate && mask_reg[LOWER_BIT]
        && lflag_reg;

    // Clockless wake: raw pin against held samples
    assign wake_o =
        (mask_reg[DEDICATED_BIT] && (sense_reg == SENSE_LOW_LEVEL)
         && !dedicated_ext_irq_i)
        || (mask_reg[UPPER_BIT]
            && |((pin_change_inputs_i[15:8] ^ pc_cur[15:8]) & pcu_reg))
        || (mask_reg[LOWER_BIT]
            && |((pin_change_inputs_i[7:0] ^ pc_cur[7:0]) & pcl_reg));

    // ========================================================
    // Bus answer: one wait cycle, zero for unmapped words
    logic [7:0] rd_byte;

    always_comb
    begin
        rd_byte = 8'h00;
        if (hit_ctl)
        begin
            rd_byte[SELECT_BIT] = select_reg;
            rd_byte[UNLOCK_BIT] = unlock_bit;
        end
        else if (hit_flag)
        begin
            rd_byte[UPPER_BIT]     = uflag_reg;
            rd_byte[LOWER_BIT]     = lflag_reg;
            rd_byte[DEDICATED_BIT] = dflag_reg;
        end
        else if (hit_mask)
            rd_byte = mask_reg;
        else if (hit_sense)
            rd_byte = {6'h00, sense_reg};
        else if (hit_pcl)
            rd_byte = pcl_reg;
        else if (hit_pcu)
            rd_byte = pcu_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // ========================================================
    // Assertions
    sequence unlock_start_s;
        $rose(unlock_bit);
    endsequence

    sequence no_select_s;
        (!sel_wr && !unlock_wr) [*4];
    endsequence

    block_unlock_a: assert property (@(posedge clk_i) disable iff (rst_i)
        unlock_bit |-> irq_block_o)
        else $error("interrupts not blocked during unlock");

    unlock_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
        unlock_start_s ##0 no_select_s
        |=> !unlock_bit)
        else $error("unlock window not closed after four cycles");

    unlock_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        unlock_start_s ##1 (!sel_wr && !unlock_wr) [*2]
        |=> unlock_bit)
        else $error("unlock window closed too early");

    select_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        sel_wr |=> !unlock_bit && irq_block_o
        && (vector_base_select_o == $past(dat_i[SELECT_BIT])))
        else $error("select write not applied");

    level_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
        level_low && mask_reg[DEDICATED_BIT] && global_irq_enable_i
        && !irq_block_o |-> dedicated_irq_req_o)
        else $error("level request missing");

    level_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (sense_reg == SENSE_LOW_LEVEL) |=> !dflag_reg)
        else $error("flag set in level mode");

    edge_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (sense_reg == SENSE_RISING) && !pin_cur ##1 pin_cur
        && (sense_reg == SENSE_RISING) |=> dflag_reg)
        else $error("rising edge not flagged");

    group_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (|chg_upper) |=> uflag_reg)
        else $error("upper pin change not flagged");

    req_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dedicated_irq_req_o |-> global_irq_enable_i
        && mask_reg[DEDICATED_BIT])
        else $error("dedicated request without enables");

    section_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        select_reg && app_section_lock_i && !exec_in_boot_i
        |-> !dedicated_irq_req_o && !pin_change_irq_lower_o)
        else $error("request while application section suppressed");

endmodule

// ==== hw/ext_irq_pkg.sv ====
/*
  Constants for the external interrupt front-end: register word indices,
  field positions, reset values and sequence timing.
  Assumes a 32-bit classic Wishbone slave port, byte address = 4 * index.
*/
package ext_irq_pkg;

    // ========================================================
    // Register word indices (byte address is four times these)
    localparam logic [8:0] IDX_CPU_CONTROL    = 9'h035;
    localparam logic [8:0] IDX_EXT_IRQ_FLAG   = 9'h03c;
    localparam logic [8:0] IDX_EXT_IRQ_MASK   = 9'h03d;
    localparam logic [8:0] IDX_SENSE_CONTROL  = 9'h069;
    localparam logic [8:0] IDX_PC_MASK_LOWER  = 9'h06b;
    localparam logic [8:0] IDX_PC_MASK_UPPER  = 9'h06c;

    // ========================================================
    // Field positions
    localparam int UNLOCK_BIT     = 0;
    localparam int SELECT_BIT     = 1;
    localparam int DEDICATED_BIT  = 0;
    localparam int LOWER_BIT      = 4;
    localparam int UPPER_BIT      = 5;
    localparam int SENSE_LO_BIT   = 0;
    localparam int SENSE_HI_BIT   = 1;

    // ========================================================
    // Reset values
    localparam logic [7:0] MASK_RESET   = 8'h00;
    localparam logic [1:0] SENSE_RESET  = 2'h0;
    localparam logic [7:0] PC_RESET     = 8'h00;

    // ========================================================
    // Sense modes of the dedicated pin
    typedef enum logic [1:0]
    {
        SENSE_LOW_LEVEL = 2'h0,
        SENSE_ANY_EDGE  = 2'h1,
        SENSE_FALLING   = 2'h2,
        SENSE_RISING    = 2'h3
    } sense_mode_t;

    // ========================================================
    // Relocation sequence
    localparam int         UNLOCK_CYCLES = 4;
    localparam logic [2:0] UNLOCK_LOAD   = 3'(UNLOCK_CYCLES - 1);

    typedef enum logic [2:0]
    {
        SEQ_IDLE   = 3'b001,
        SEQ_WINDOW = 3'b010,
        SEQ_HOLD   = 3'b100
    } seq_state_t;

endpackage

// ==== bench/core_model.sv ====
/*
  Behavioural model of the processor core beside the interrupt block.
  Assumes one clock shared with the block; the bench gates instruction
  completion and vector entry so that each scenario can hold them off.
*/
`timescale 1ns/1ns

module core_model
#(
    parameter int GAP = 3,
    parameter int LAT = 1
)
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Bench controls
    input  wire logic       run_i,
    input  wire logic       take_i,
    // Requests from the block
    input  wire logic [2:0] req_i,
    // Core responses
    output logic            instr_done_o,
    output logic [2:0]      entry_o
);
    int gap_cnt;
    int lat_cnt [3];

    // ========================================================
    // Instruction completion pulse every GAP cycles while running
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            gap_cnt      <= 0;
            instr_done_o <= 1'b0;
        end
        else
        begin
            gap_cnt      <= (gap_cnt == GAP - 1) ? 0 : gap_cnt + 1;
            instr_done_o <= (gap_cnt == GAP - 1);
        end
    end

    // Vector entry once a request has stood LAT+1 cycles
    always_ff @(posedge clk_i)
    begin
        for (int k = 0; k < 3; k++)
        begin
            if (rst_i || !take_i || !req_i[k] || entry_o[k])
            begin
                lat_cnt[k] <= 0;
                entry_o[k] <= 1'b0;
            end
            else
            begin
                lat_cnt[k] <= lat_cnt[k] + 1;
                entry_o[k] <= (lat_cnt[k] == LAT);
            end
        end
    end
endmodule

// ==== bench/tb_ext_irq_and_vector_select.sv ====
/*
  Self-checking bench: Wishbone register tasks, relocation sequence,
  section suppression, sense modes and pin-change groups.
  Assumes the core model file is compiled before this one.
*/
`timescale 1ns/1ns

module tb_ext_irq_and_vector_select;
    import ext_irq_pkg::*;

    logic        clk_i, rst_i, cyc, stb, we, ack, gie, in_boot;
    logic        app_lock, boot_lock, ded_pin, run, take, done;
    logic        req_d, req_u, req_l, blk, vsel, wake;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [15:0] pc_pins;
    logic [2:0]  entry;
    logic [7:0]  q;
    int          fail_count, num_checks;
    // Expected flag after a fall (bit 1) and after a rise (bit 0)
    localparam logic [1:0] EDGE_EXP [4] = '{2'h0, 2'h3, 2'h2, 2'h1};

    ext_irq_and_vector_select ext_irq_and_vector_select_i (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .global_irq_enable_i(gie), .exec_in_boot_i(in_boot),
        .instr_done_i(done), .app_section_lock_i(app_lock),
        .boot_section_lock_i(boot_lock), .dedicated_entry_i(entry[0]),
        .upper_entry_i(entry[2]), .lower_entry_i(entry[1]),
        .dedicated_ext_irq_i(ded_pin), .pin_change_inputs_i(pc_pins),
        .dedicated_irq_req_o(req_d), .pin_change_irq_upper_o(req_u),
        .pin_change_irq_lower_o(req_l), .irq_block_o(blk),
        .vector_base_select_o(vsel), .wake_o(wake));

    core_model core_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .take_i(take),
        .req_i({req_u, req_l, req_d}), .instr_done_o(done),
        .entry_o(entry));

    // ========================================================
    // Clock, 50 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // One classic cycle; waits for ack, takes data at that edge
    task automatic wb_cycle(input logic [8:0] idx, input logic w,
                            input logic [7:0] d, output logic [7:0] r);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= 4'h1;
        adr  <= {1'b0, idx, 2'b00};
        wdat <= {24'h00_0000, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1)
            fail_count++;
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wb_write(input logic [8:0] idx, input logic [7:0] d);
        logic [7:0] r;
        wb_cycle(idx, 1'b1, d, r);
    endtask

    task automatic wb_read(input logic [8:0] idx, output logic [7:0] r);
        wb_cycle(idx, 1'b0, 8'h00, r);
    endtask

    // Comparisons of bytes and of single bits
    task automatic chk8(string name, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", name, e, g);
            fail_count++;
        end
    endtask

    task automatic chk1(string name, logic e, logic g);
        num_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %b seen %b", name, e, g);
            fail_count++;
        end
    endtask

    // Drive pins at an edge, then let detection settle
    task automatic pins(logic d, logic [15:0] p);
        @(posedge clk_i);
        ded_pin <= d;
        pc_pins <= p;
        repeat (3) @(negedge clk_i);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        end_sim();
    end

    // ========================================================
    // Main sequence
    initial
    begin
        {cyc, stb, we, gie, in_boot, app_lock, boot_lock} = 7'h00;
        {run, take, adr, sel, wdat} = '0;
        ded_pin = 1'b1;
        pc_pins = 16'h0000;
        fail_count = 0;
        num_checks = 0;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, unmapped word and writable bits
        wb_read(IDX_EXT_IRQ_MASK, q);
        chk8("mask reset", MASK_RESET, q);
        wb_read(IDX_SENSE_CONTROL, q);
        chk8("sense reset", 8'h00, q);
        wb_read(9'h000, q);
        chk8("unmapped", 8'h00, q);
        wb_write(IDX_EXT_IRQ_MASK, 8'hff);
        wb_read(IDX_EXT_IRQ_MASK, q);
        chk8("mask bits", 8'h31, q);
        $display("test registers done");
        // Unlock without a select write: timeout release
        wb_write(IDX_CPU_CONTROL, 8'h01);
        @(negedge clk_i);
        chk1("block set", 1'b1, blk);
        wb_read(IDX_CPU_CONTROL, q);
        chk8("unlock open", 8'h01, q);
        repeat (6) @(negedge clk_i);
        chk1("block timeout", 1'b0, blk);
        wb_write(IDX_CPU_CONTROL, 8'h02);
        wb_read(IDX_CPU_CONTROL, q);
        chk8("late select", 8'h00, q);
        // Vectors in application, boot lock, running boot code
        @(posedge clk_i);
        boot_lock <= 1'b1;
        in_boot   <= 1'b1;
        @(negedge clk_i);
        chk1("boot suppress", 1'b1, blk);
        @(posedge clk_i);
        boot_lock <= 1'b0;
        in_boot   <= 1'b0;
        $display("test timeout done");
        // Full relocation: block held until next instruction completes
        wb_write(IDX_CPU_CONTROL, 8'h01);
        wb_write(IDX_CPU_CONTROL, 8'h02);
        repeat (3) @(negedge clk_i);
        chk1("select set", 1'b1, vsel);
        chk1("block held", 1'b1, blk);
        @(posedge clk_i);
        run <= 1'b1;
        for (int n = 0; n < 20 && blk !== 1'b0; n++)
            @(negedge clk_i);
        chk1("block release", 1'b0, blk);
        @(posedge clk_i);
        run      <= 1'b0;
        app_lock <= 1'b1;
        wb_read(IDX_CPU_CONTROL, q);
        chk8("unlock cleared", 8'h02, q);
        chk1("app suppress", 1'b1, blk);
        @(posedge clk_i);
        app_lock <= 1'b0;
        gie      <= 1'b1;
        $display("test relocation done");
        // Every sense mode with a fall then a rise
        for (int m = 0; m < 4; m++)
        begin
            wb_write(IDX_SENSE_CONTROL, 8'(m));
            wb_write(IDX_EXT_IRQ_FLAG, 8'h01);
            pins(1'b0, 16'h0000);
            if (m == 0)
                chk1("level request", 1'b1, req_d);
            if (m == 0)
                chk1("level wake", 1'b1, wake);
            wb_read(IDX_EXT_IRQ_FLAG, q);
            chk8("fall flag", {7'h00, EDGE_EXP[m][1]}, q);
            wb_write(IDX_EXT_IRQ_FLAG, 8'h01);
            pins(1'b1, 16'h0000);
            wb_read(IDX_EXT_IRQ_FLAG, q);
            chk8("rise flag", {7'h00, EDGE_EXP[m][0]}, q);
            chk1("edge request", EDGE_EXP[m][0], req_d);
            wb_write(IDX_EXT_IRQ_FLAG, 8'h01);
        end
        $display("test sense done");
        // Pin-change groups with individual masks
        wb_write(IDX_PC_MASK_LOWER, 8'h01);
        wb_write(IDX_PC_MASK_UPPER, 8'h80);
        pins(1'b1, 16'h0002);
        wb_read(IDX_EXT_IRQ_FLAG, q);
        chk8("masked pin", 8'h00, q);
        pins(1'b1, 16'h0003);
        chk1("lower request", 1'b1, req_l);
        pins(1'b1, 16'h8003);
        chk1("upper request", 1'b1, req_u);
        wb_read(IDX_EXT_IRQ_FLAG, q);
        chk8("group flags", 8'h30, q);
        wb_write(IDX_EXT_IRQ_FLAG, 8'h30);
        wb_read(IDX_EXT_IRQ_FLAG, q);
        chk8("flags cleared", 8'h00, q);
        @(posedge clk_i);
        take <= 1'b1;
        pins(1'b1, 16'h0000);
        repeat (5) @(negedge clk_i);
        wb_read(IDX_EXT_IRQ_FLAG, q);
        chk8("entry clear", 8'h00, q);
        $display("test pin change done");
        end_sim();
    end
endmodule
